// file: shared/bec_defines.svh
/*
  Constants of the event counter: register offsets, field positions, reset values.
  Assumes inclusion by bare name from design files.
*/
`ifndef BEC_DEFINES_SVH
`define BEC_DEFINES_SVH
`define BEC_OFS_CTRL 4'h0
`define BEC_OFS_ACTRL 4'h1
`define BEC_OFS_CNT_LO 4'h2
`define BEC_OFS_CNT_MID 4'h3
`define BEC_OFS_CNT_HI 4'h4
`define BEC_OFS_ALM_LO 4'h5
`define BEC_OFS_ALM_MID 4'h6
`define BEC_OFS_ALM_HI 4'h7
`define BEC_OFS_TIMER 4'h8
`define BEC_OFS_STATUS 4'h9
`define BEC_OFS_MASK 4'hA
`define BEC_MODE_LSB 4
`define BEC_MODE_EVENT 2'h2
`define BEC_CTRL_OSC_RUN 6
`define BEC_NUM_DIGITS 6
`define BEC_CNT_MAX 24'h999999
`define BEC_PIN_IDLE 1'b1
`define BEC_ACTRL_AIE 7
`define BEC_ACTRL_AEN 4
`define BEC_ACTRL_SC_LSB 0
`define BEC_ST_ALARM 0
`define BEC_ST_TIMER 1
`define BEC_ST_ZERO 2'h0
`define BEC_SC_1 2'h0
`define BEC_SC_100 2'h1
`define BEC_SC_10K 2'h2
`define BEC_DIGIT_MAX 4'h9
`define BEC_RST_BYTE 8'h00
`define BEC_RST_CNT 24'h000000
`define BEC_RST_TIMER 8'h00
`define BEC_BYTE_WORD_PAD 24'h000000
`define BEC_WORD_ZERO 32'h00000000
`endif

// file: shared/bec_pkg.sv
/*
  Types of the event counter: bus request carrier and the state record.
  Assumes bec_defines.svh is reachable on the include path.
*/
package bec_pkg;
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } bec_req_t;

  typedef enum logic [1:0] {
    BEC_AW_IDLE = 2'b00,
    BEC_AW_ACK = 2'b01
  } bec_bus_t;

  typedef struct packed {
    bec_bus_t bus;
    logic [31:0] readdata;
    logic [7:0] ctrl;
    logic [7:0] actrl;
    logic [23:0] cnt;
    logic [23:0] alm;
    logic [7:0] timer;
    logic [1:0] status;
    logic [1:0] mask;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic armed;
    logic match_prev;
  } bec_state_t;
endpackage

// file: hdl/bec_event_counter.sv
/*
  Event-counting mode of a clock device: six-digit BCD event counter, event alarm,
  scaled timer and interrupt, registers reached over Avalon-MM with waitrequest.
  Assumes a 100 MHz clock, an asynchronous active-low reset and a pulse source on
  the pulse input pin that is slow against the clock.
*/
// Summary of operation
// - Event mode entered when software writes mode bits of control register.
// - In event mode oscillator stops and pulse input pin is released.
// - In event mode pulses on pulse input pin are counted.
// - Count is six BCD digits in three byte registers.
// - Top digit most significant, digits 0..9, up to 999999.
// - Alarm enabled: flag set when count equals programmed alarm value.
// - Alarm interrupt enable drives interrupt pin with inverted alarm flag.
// - Timer advances once per 1, 100, 10000 or 1000000 events.
// - Powers up in clock mode (mode bits zero); oscillator stays off until configured.
// - Count increments on each falling edge of pulse input.
// - After reset or count write, falling edges ignored until a rising edge.
`timescale 1ns/1ns
`include "bec_defines.svh"
module bec_event_counter
  import bec_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pulse_input_pin,
  output logic pulse_input_oe,
  output logic oscillator_enable,
  output logic oscillator_output_pin,
  output logic irq,
  output logic interrupt_n
);
  bec_state_t cur;
  bec_state_t nxt;
  bec_req_t req;
  logic event_mode;
  logic fall;
  logic rise;
  logic cnt_wr;
  logic match;
  logic [23:0] inc_cnt;
  logic tick;
  logic timer_wr;

  // Increment one BCD count, nine wraps with carry
  function automatic logic [23:0] bec_bcd_inc(input logic [23:0] v);
    logic [23:0] r;
    logic carry;
    r = v;
    carry = 1'b1;
    for (int i = 0; i < `BEC_NUM_DIGITS; i++) begin
      if (carry) begin
        if (v[i*4 +: 4] >= `BEC_DIGIT_MAX) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // True when every digit of a count holds 0 to 9
  function automatic logic bec_is_bcd(input logic [23:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < `BEC_NUM_DIGITS; i++) begin
      if (v[i*4 +: 4] > `BEC_DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // True when the low n digits of the new count are all zero
  function automatic logic bec_low_zero(input logic [23:0] v, input logic [1:0] sc);
    logic z;
    z = 1'b1;
    case (sc)
      `BEC_SC_1: z = 1'b1;
      `BEC_SC_100: z = (v[7:0] == `BEC_RST_BYTE);
      `BEC_SC_10K: z = (v[15:0] == {`BEC_RST_BYTE, `BEC_RST_BYTE});
      default: z = (v == `BEC_RST_CNT);
    endcase
    return z;
  endfunction

  assign req = '{read: avs_read, write: avs_write, address: avs_address, writedata: avs_writedata};
  assign event_mode = (cur.ctrl[`BEC_MODE_LSB +: 2] == `BEC_MODE_EVENT);
  // Only the second synchroniser stage feeds edge detection
  assign fall = cur.pin_prev & ~cur.pin_s2;
  assign rise = ~cur.pin_prev & cur.pin_s2;
  assign inc_cnt = bec_bcd_inc(cur.cnt);
  assign tick = event_mode & fall & cur.armed;
  assign cnt_wr = (cur.bus == BEC_AW_ACK) & req.write &
                  (req.address inside {`BEC_OFS_CNT_LO, `BEC_OFS_CNT_MID, `BEC_OFS_CNT_HI});
  assign timer_wr = (cur.bus == BEC_AW_ACK) & req.write & (req.address == `BEC_OFS_TIMER);
  assign match = cur.actrl[`BEC_ACTRL_AEN] & (cur.cnt == cur.alm);

  always_comb begin
    nxt = cur;
    nxt.pin_s1 = pulse_input_pin;
    nxt.pin_s2 = cur.pin_s1;
    nxt.pin_prev = cur.pin_s2;
    nxt.match_prev = match;
    if (rise) begin
      nxt.armed = 1'b1;
    end
    if (tick) begin
      nxt.cnt = inc_cnt;
      if (bec_low_zero(inc_cnt, cur.actrl[`BEC_ACTRL_SC_LSB +: 2])) begin
        nxt.timer = cur.timer + 8'h01;
        nxt.status[`BEC_ST_TIMER] = 1'b1;
      end
    end
    // Alarm on arrival at the match so a held match does not refire after clear
    if (match & ~cur.match_prev) begin
      nxt.status[`BEC_ST_ALARM] = 1'b1;
    end
    nxt.bus = BEC_AW_IDLE;
    if (cur.bus == BEC_AW_IDLE && (req.read || req.write)) begin
      nxt.bus = BEC_AW_ACK;
      nxt.readdata = `BEC_WORD_ZERO;
      if (req.read) begin
        case (req.address)
          `BEC_OFS_CTRL: nxt.readdata = {`BEC_BYTE_WORD_PAD, cur.ctrl};
          `BEC_OFS_ACTRL: nxt.readdata = {`BEC_BYTE_WORD_PAD, cur.actrl};
          `BEC_OFS_CNT_LO: nxt.readdata = {`BEC_BYTE_WORD_PAD, cur.cnt[7:0]};
          `BEC_OFS_CNT_MID: nxt.readdata = {`BEC_BYTE_WORD_PAD, cur.cnt[15:8]};
          `BEC_OFS_CNT_HI: nxt.readdata = {`BEC_BYTE_WORD_PAD, cur.cnt[23:16]};
          `BEC_OFS_ALM_LO: nxt.readdata = {`BEC_BYTE_WORD_PAD, cur.alm[7:0]};
          `BEC_OFS_ALM_MID: nxt.readdata = {`BEC_BYTE_WORD_PAD, cur.alm[15:8]};
          `BEC_OFS_ALM_HI: nxt.readdata = {`BEC_BYTE_WORD_PAD, cur.alm[23:16]};
          `BEC_OFS_TIMER: nxt.readdata = {`BEC_BYTE_WORD_PAD, cur.timer};
          `BEC_OFS_STATUS: nxt.readdata = {30'h00000000, cur.status};
          `BEC_OFS_MASK: nxt.readdata = {30'h00000000, cur.mask};
          default: nxt.readdata = `BEC_WORD_ZERO;
        endcase
      end
    end
    // Writes land on the edge that completes the transfer, not while it waits
    if (cur.bus == BEC_AW_ACK && req.write) begin
      case (req.address)
        `BEC_OFS_CTRL: nxt.ctrl = req.writedata[7:0];
        `BEC_OFS_ACTRL: nxt.actrl = req.writedata[7:0];
        `BEC_OFS_CNT_LO: nxt.cnt[7:0] = req.writedata[7:0];
        `BEC_OFS_CNT_MID: nxt.cnt[15:8] = req.writedata[7:0];
        `BEC_OFS_CNT_HI: nxt.cnt[23:16] = req.writedata[7:0];
        `BEC_OFS_ALM_LO: nxt.alm[7:0] = req.writedata[7:0];
        `BEC_OFS_ALM_MID: nxt.alm[15:8] = req.writedata[7:0];
        `BEC_OFS_ALM_HI: nxt.alm[23:16] = req.writedata[7:0];
        `BEC_OFS_TIMER: nxt.timer = req.writedata[7:0];
        // Write one clears, a same-cycle event wins only where the flag was still clear
        `BEC_OFS_STATUS: nxt.status = nxt.status & ~(req.writedata[1:0] & ~(nxt.status ^ cur.status));
        `BEC_OFS_MASK: nxt.mask = req.writedata[1:0];
        default: nxt.mask = cur.mask;
      endcase
    end
    if (cnt_wr) begin
      nxt.armed = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Mode reads as clock mode with oscillator off until software writes it
      cur.bus <= BEC_AW_IDLE;
      cur.readdata <= `BEC_WORD_ZERO;
      cur.ctrl <= `BEC_RST_BYTE;
      cur.actrl <= `BEC_RST_BYTE;
      cur.cnt <= `BEC_RST_CNT;
      cur.alm <= `BEC_RST_CNT;
      cur.timer <= `BEC_RST_TIMER;
      cur.status <= `BEC_ST_ZERO;
      cur.mask <= `BEC_ST_ZERO;
      // Synchroniser starts at the idle level, so release makes no false rise
      cur.pin_s1 <= `BEC_PIN_IDLE;
      cur.pin_s2 <= `BEC_PIN_IDLE;
      cur.pin_prev <= `BEC_PIN_IDLE;
      cur.armed <= 1'b0;
      cur.match_prev <= 1'b0;
    end else begin
      cur <= nxt;
    end
  end

  assign avs_waitrequest = (req.read | req.write) & (cur.bus == BEC_AW_IDLE);
  assign avs_readdata = cur.readdata;
  // Oscillator runs only after a valid clock-mode setting is written
  assign oscillator_enable = ~event_mode & cur.ctrl[`BEC_CTRL_OSC_RUN];
  assign pulse_input_oe = 1'b0;
  assign oscillator_output_pin = 1'b0;
  assign interrupt_n = ~(cur.actrl[`BEC_ACTRL_AIE] & cur.status[`BEC_ST_ALARM]);
  assign irq = |(cur.status & cur.mask);

  property p_alarm_set;
    @(posedge clock) disable iff (!rst_n)
      (match && !cur.match_prev) |=> cur.status[`BEC_ST_ALARM];
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag missed on match");

  property p_int_pin;
    @(posedge clock) disable iff (!rst_n)
      interrupt_n == !(cur.actrl[`BEC_ACTRL_AIE] && cur.status[`BEC_ST_ALARM]);
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("interrupt pin wrong");

  property p_count_inc;
    @(posedge clock) disable iff (!rst_n)
      (tick && !cnt_wr) |=> cur.cnt == $past(inc_cnt);
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("count not incremented");

  property p_no_count_idle;
    @(posedge clock) disable iff (!rst_n)
      (!event_mode && !cnt_wr) |=> $stable(cur.cnt);
  endproperty
  a_no_count_idle: assert property (p_no_count_idle) else $error("count moved outside event mode");

  property p_disarm;
    @(posedge clock) disable iff (!rst_n)
      cnt_wr |=> !cur.armed;
  endproperty
  a_disarm: assert property (p_disarm) else $error("not disarmed after count write");

  property p_osc_off;
    @(posedge clock) disable iff (!rst_n)
      event_mode |-> !oscillator_enable && !pulse_input_oe;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator active in event mode");

  property p_digits;
    @(posedge clock) disable iff (!rst_n)
      (tick && !cnt_wr && cur.cnt[3:0] == `BEC_DIGIT_MAX) |=> cur.cnt[3:0] == 4'h0;
  endproperty
  a_digits: assert property (p_digits) else $error("digit did not wrap");

  property p_timer_unit;
    @(posedge clock) disable iff (!rst_n)
      (tick && cur.actrl[`BEC_ACTRL_SC_LSB +: 2] == `BEC_SC_1 && !timer_wr)
        |=> cur.timer == $past(cur.timer) + 8'h01;
  endproperty
  a_timer_unit: assert property (p_timer_unit) else $error("timer not advanced per event");

  property p_mode_enter;
    @(posedge clock) disable iff (!rst_n)
      (cur.bus == BEC_AW_ACK && avs_write && avs_address == `BEC_OFS_CTRL &&
        avs_writedata[`BEC_MODE_LSB +: 2] == `BEC_MODE_EVENT) |=> event_mode;
  endproperty
  a_mode_enter: assert property (p_mode_enter) else $error("event mode not entered");

  property p_osc_out_idle;
    @(posedge clock) disable iff (!rst_n)
      event_mode |-> !oscillator_output_pin;
  endproperty
  a_osc_out_idle: assert property (p_osc_out_idle) else $error("oscillator output active");

  property p_osc_needs_run;
    @(posedge clock) disable iff (!rst_n)
      !cur.ctrl[`BEC_CTRL_OSC_RUN] |-> !oscillator_enable;
  endproperty
  a_osc_needs_run: assert property (p_osc_needs_run) else $error("oscillator on before setup");

  property p_fall_only;
    @(posedge clock) disable iff (!rst_n)
      (!fall && !cnt_wr) |=> $stable(cur.cnt);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("count moved without falling edge");

  property p_hold_disarmed;
    @(posedge clock) disable iff (!rst_n)
      (!cur.armed && !cnt_wr) |=> $stable(cur.cnt);
  endproperty
  a_hold_disarmed: assert property (p_hold_disarmed) else $error("count moved while disarmed");

  property p_arm_on_rise;
    @(posedge clock) disable iff (!rst_n)
      (rise && !cnt_wr) |=> cur.armed;
  endproperty
  a_arm_on_rise: assert property (p_arm_on_rise) else $error("rising edge did not arm");

  property p_bcd_kept;
    @(posedge clock) disable iff (!rst_n)
      (tick && !cnt_wr && bec_is_bcd(cur.cnt)) |=> bec_is_bcd(cur.cnt);
  endproperty
  a_bcd_kept: assert property (p_bcd_kept) else $error("digit left decimal range");

  property p_wrap_full;
    @(posedge clock) disable iff (!rst_n)
      (tick && !cnt_wr && cur.cnt == `BEC_CNT_MAX) |=> cur.cnt == `BEC_RST_CNT;
  endproperty
  a_wrap_full: assert property (p_wrap_full) else $error("full count did not wrap");

  property p_carry;
    @(posedge clock) disable iff (!rst_n)
      (tick && !cnt_wr && cur.cnt[3:0] == `BEC_DIGIT_MAX && cur.cnt[7:4] < `BEC_DIGIT_MAX)
        |=> cur.cnt[7:4] == $past(cur.cnt[7:4]) + 4'h1;
  endproperty
  a_carry: assert property (p_carry) else $error("carry not passed on");

  property p_cnt_byte_wr;
    @(posedge clock) disable iff (!rst_n)
      (cur.bus == BEC_AW_ACK && avs_write && avs_address == `BEC_OFS_CNT_MID)
        |=> cur.cnt[15:8] == $past(avs_writedata[7:0]);
  endproperty
  a_cnt_byte_wr: assert property (p_cnt_byte_wr) else $error("count byte write lost");

  property p_cnt_byte_rd;
    @(posedge clock) disable iff (!rst_n)
      (cur.bus == BEC_AW_IDLE && avs_read && avs_address == `BEC_OFS_CNT_HI)
        |=> avs_readdata[7:0] == $past(cur.cnt[23:16]);
  endproperty
  a_cnt_byte_rd: assert property (p_cnt_byte_rd) else $error("count byte read wrong");

  property p_alarm_only_match;
    @(posedge clock) disable iff (!rst_n)
      (!(match && !cur.match_prev) && !cur.status[`BEC_ST_ALARM]) |=> !cur.status[`BEC_ST_ALARM];
  endproperty
  a_alarm_only_match: assert property (p_alarm_only_match) else $error("alarm flag without match");

  property p_int_when_enabled;
    @(posedge clock) disable iff (!rst_n)
      !cur.actrl[`BEC_ACTRL_AIE] |-> interrupt_n;
  endproperty
  a_int_when_enabled: assert property (p_int_when_enabled) else $error("interrupt pin low while disabled");

  property p_timer_hold;
    @(posedge clock) disable iff (!rst_n)
      (!tick && !timer_wr) |=> $stable(cur.timer);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer moved without event");

  property p_timer_flag;
    @(posedge clock) disable iff (!rst_n)
      (tick && bec_low_zero(inc_cnt, cur.actrl[`BEC_ACTRL_SC_LSB +: 2])) |=> cur.status[`BEC_ST_TIMER];
  endproperty
  a_timer_flag: assert property (p_timer_flag) else $error("timer flag not set");

  property p_bus_answer;
    @(posedge clock) disable iff (!rst_n)
      (cur.bus == BEC_AW_IDLE && (avs_read || avs_write)) |=> cur.bus == BEC_AW_ACK;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered");
endmodule

// file: test/bec_pulse_src.sv
/*
  External pulse source that drives the pulse input pin in event mode.
  Assumes the bench raises go for one cycle with count and half period set.
*/
`timescale 1ns/1ns
module bec_pulse_src
  import bec_pkg::*;
(
  input wire logic clock,
  input wire logic go,
  input wire logic [7:0] count,
  input wire logic [3:0] half,
  output logic pin = 1'b1,
  output logic busy = 1'b0
);
  logic [7:0] left = 8'h00;
  logic [4:0] t = 5'h00;
  // Idle high, so the first fall after a count write has no rise before it
  always @(posedge clock) begin
    if (!busy) begin
      if (go && count != 8'h00) begin
        busy <= 1'b1;
        left <= count;
        t <= 5'h00;
      end
    end else begin
      t <= t + 5'h01;
      // One event per falling edge, no crystal behind the pin
      if (t == {1'b0, half} - 5'h01) pin <= 1'b0;
      // Rise re-arms counting after a count write
      if (t == {half, 1'b0} - 5'h01) begin
        pin <= 1'b1;
        t <= 5'h00;
        left <= left - 8'h01;
        if (left == 8'h01) busy <= 1'b0;
      end
    end
  end
endmodule

// file: test/bec_event_counter_tb.sv
/*
  Bench of the event counter: Avalon-MM tasks, pulse source, compared sequences.
  Assumes the design answers every access within the watchdog span.
*/
`timescale 1ns/1ns
module bec_event_counter_tb import bec_pkg::*; ;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, pulse_input_pin, pulse_input_oe, oscillator_enable;
  logic oscillator_output_pin, irq, interrupt_n, busy;
  logic go = 1'b0;
  logic [7:0] cnt_n = 8'h00;
  logic [3:0] half = 4'h6;
  int failures = 0;
  int check_count = 0;
  always #5 clock = ~clock;
  bec_event_counter i_bec_event_counter (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pulse_input_pin(pulse_input_pin), .pulse_input_oe(pulse_input_oe),
    .oscillator_enable(oscillator_enable), .oscillator_output_pin(oscillator_output_pin), .irq(irq),
    .interrupt_n(interrupt_n));
  bec_pulse_src i_bec_pulse_src (.clock(clock), .go(go), .count(cnt_n), .half(half), .pin(pulse_input_pin),
    .busy(busy));
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    logic wt;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    // Request stands until the edge that samples waitrequest low
    do begin
      @(posedge clock);
      wt = avs_waitrequest;
      q = avs_readdata;
    end while (wt !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(nm, {24'h000000, e}, q);
  endtask
  task automatic set_cnt(input logic [23:0] v);
    wr(4'h2, v[7:0]);
    wr(4'h3, v[15:8]);
    wr(4'h4, v[23:16]);
  endtask
  task automatic cnt_is(input logic [23:0] v);
    rdc(4'h2, v[7:0], "cnt_lo");
    rdc(4'h3, v[15:8], "cnt_mid");
    rdc(4'h4, v[23:16], "cnt_hi");
  endtask
  task automatic pulses(input logic [7:0] k, input logic [3:0] h);
    @(posedge clock);
    go <= 1'b1;
    cnt_n <= k;
    half <= h;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    while (busy) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    results();
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk("osc_en", 32'h0, {31'h0, oscillator_enable});
    wr(4'h0, 8'h40);
    @(negedge clock);
    chk("osc_en", 32'h1, {31'h0, oscillator_enable});
    wr(4'h0, 8'h60);
    @(negedge clock);
    chk("osc_en", 32'h0, {31'h0, oscillator_enable});
    chk("pin_oe", 32'h0, {31'h0, pulse_input_oe});
    chk("osc_out", 32'h0, {31'h0, oscillator_output_pin});
    rdc(4'hF, 8'h00, "unmapped");
    wr(4'h1, 8'h00);
    wr(4'hA, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h00);
    wr(4'h9, 8'h03);
    set_cnt(24'h000008);
    pulses(8'd5, 4'h6);
    cnt_is(24'h000012);
    set_cnt(24'h099999);
    pulses(8'd2, 4'hC);
    cnt_is(24'h100000);
    for (int s = 0; s < 4; s++) begin
      wr(4'h1, 8'(s));
      wr(4'h8, 8'h00);
      wr(4'h9, 8'h03);
      set_cnt(24'h999998);
      pulses(8'd3, 4'h6);
      cnt_is(24'h000000);
      rdc(4'h8, (s == 0) ? 8'h02 : 8'h01, "timer");
      rdc(4'h9, 8'h02, "status");
    end
    wr(4'h1, 8'h13);
    wr(4'h5, 8'h03);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'hA, 8'h01);
    set_cnt(24'h000000);
    wr(4'h9, 8'h03);
    pulses(8'd4, 4'h6);
    cnt_is(24'h000003);
    rdc(4'h9, 8'h01, "status");
    @(negedge clock);
    chk("irq", 32'h1, {31'h0, irq});
    chk("int_n", 32'h1, {31'h0, interrupt_n});
    wr(4'h1, 8'h93);
    @(negedge clock);
    chk("int_n", 32'h0, {31'h0, interrupt_n});
    wr(4'h9, 8'h01);
    rdc(4'h9, 8'h00, "status");
    @(negedge clock);
    chk("irq", 32'h0, {31'h0, irq});
    chk("int_n", 32'h1, {31'h0, interrupt_n});
    results();
  end
endmodule
